// >>> rtl/bus_groups_defines.svh
// Widths, field positions, reset values and timing counts of the bus signal group block
`ifndef BUS_GROUPS_DEFINES_SVH
`define BUS_GROUPS_DEFINES_SVH

// Data path: four 16-bit lanes, lowest lane first
`define LANE_W 16
`define LANE_CNT 4
`define DATA_W 64
`define LANE_INV_LIMIT 5'h08

// Asynchronous side-band inputs, bit positions in the side-band vector
`define SB_W 6
`define SB_A20 0
`define SB_NUMERIC_ERROR_IGNORE 1
`define SB_IRQ_A 2
`define SB_IRQ_B 3
`define SB_INIT 4
`define SB_SMI 5

// Wired-OR group, bit positions
`define WOR_W 4
`define WOR_REINIT 0
`define WOR_BNR 1
`define WOR_SNOOP_MODIFIED_MATCH 2
`define WOR_MACHINE_CHECK_ERROR 3

// Arbitration requests this agent drives
`define ARB_W 2

// Reset-release straps
`define RATIO_W 4
`define ADDR_STRAP_W 14
`define CFG_W 16
`define RATIO_RST 4'h0
`define CFG_RST 16'h0000

// Bus clocks an asynchronous input must stand before it is recognised
`define SB_HOLD_CYC 2

`endif

// >>> rtl/bus_groups_pkg.sv
// Types shared by the bus signal group block
package bus_groups_pkg;

    // Receive word handed from the strobe domain to the bus clock domain
    typedef struct packed {
        logic [63:0] data;
    } lane_word_t;

    // Bus clock domain state
    typedef struct packed {
        logic rst_d;
        logic [3:0] ratio;
        logic [15:0] cfg;
        logic [5:0] sb_prev;
        logic [5:0] sb_valid;
        logic ads_seen;
        logic ads_drv;
        logic [3:0] wor_seen;
        logic [3:0] wor_drv;
        logic [1:0] arb_drv;
        logic hot_drv;
        logic hot_ext;
        logic ack_tgl;
        logic req_prev;
        lane_word_t rx;
        logic rx_valid;
        logic [63:0] tx_data;
        logic [3:0] tx_inv;
        logic tx_oe;
    } core_st_t;

    // Strobe domain state
    typedef struct packed {
        lane_word_t cap;
        logic req_tgl;
    } link_st_t;

endpackage

// >>> rtl/sync_two_stage.sv
// Two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ns
module sync_two_stage #(
    parameter int W = 1
) (
    // Clock of the receiving domain
    input wire logic clk_in,
    // Level from another domain or a pin
    input wire logic [W-1:0] d_in,
    // Level safe to use in the receiving domain
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;

    // No reset: strap levels must flow through while reset is held
    always_ff @(posedge clk_in) begin
        meta_ff <= d_in;
        q_out <= meta_ff;
    end
endmodule

// >>> rtl/bus_signal_groups.sv
// Device-side system bus signal groups: common-clock, strobe-captured, async and straps
//
// Function
// - Common-clock signals timed to bus clock rising edge
// - Source-synchronous groups captured on own strobe
// - Async side-band inputs accepted at any time
// - Data in four 16-bit lanes with inversion
// - Only arbitration requests zero and one driven
// - Multiplier straps latched at reset release
// - Configuration straps latched at reset release
// - Snoop and error signals are wired-OR
// - Thermal pin bidirectional except output-only stepping
`timescale 1ns/1ns
`include "bus_groups_defines.svh"
module bus_signal_groups #(
    parameter bit THERM_OUTPUT_ONLY = 1'b0,
    parameter int LANE_INV_LIMIT = `LANE_INV_LIMIT
) (
    // Bus clock zero and synchronous reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Data strobe clock of the receive link
    input wire logic strobe_clk_in,
    // Common-clock address strobe, open drain, active low
    input wire logic address_strobe_common_n_in,
    output logic address_strobe_common_n_out,
    output logic address_strobe_common_oe_out,
    // Wired-OR group: reinit, block next, modified match, machine check
    input wire logic [`WOR_W-1:0] wor_n_in,
    output logic [`WOR_W-1:0] wor_n_out,
    output logic [`WOR_W-1:0] wor_oe_out,
    // Arbitration requests zero and one
    output logic [`ARB_W-1:0] arb_request_n_out,
    output logic [`ARB_W-1:0] arb_request_oe_out,
    // Asynchronous side-band pins, active low except the two local interrupt pins
    input wire logic gate_a20_mask_n_in,
    input wire logic numeric_error_ignore_n_in,
    input wire logic local_irq_pin_a_in,
    input wire logic local_irq_pin_b_in,
    input wire logic soft_init_n_in,
    input wire logic management_interrupt_n_in,
    input wire logic [`ADDR_STRAP_W-1:0] addr_strap_n_in,
    // Thermal throttle indicator, open drain, active low
    input wire logic thermal_throttle_indicator_n_in,
    output logic thermal_throttle_indicator_n_out,
    output logic thermal_throttle_indicator_oe_out,
    // Receive lanes on the strobe clock, active low pins
    input wire logic [`DATA_W-1:0] data_lane_n_in,
    input wire logic [`LANE_CNT-1:0] lane_inversion_flags_n_in,
    input wire logic lane_capture_in,
    // Transmit lanes, active low pins
    output logic [`DATA_W-1:0] data_lane_n_out,
    output logic [`LANE_CNT-1:0] lane_inversion_flags_n_out,
    output logic data_lane_oe_out,
    // Core side requests
    input wire logic ads_req_in,
    input wire logic [`WOR_W-1:0] wor_req_in,
    input wire logic [`ARB_W-1:0] arb_req_in,
    input wire logic hot_req_in,
    input wire logic tx_valid_in,
    input wire logic [`DATA_W-1:0] tx_data_in,
    // Core side results
    output logic ads_seen_out,
    output logic [`WOR_W-1:0] wor_seen_out,
    output logic [`SB_W-1:0] sideband_out,
    output logic hot_ext_out,
    output logic [`RATIO_W-1:0] core_ratio_out,
    output logic [`CFG_W-1:0] config_opts_out,
    output logic [`DATA_W-1:0] rx_data_out,
    output logic rx_valid_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Lane helpers

    // Count of ones in one lane
    function automatic logic [4:0] ones16(input logic [`LANE_W-1:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < `LANE_W; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

    // Undo or apply lane inversion, lowest lane first
    function automatic logic [`DATA_W-1:0] lane_flip(input logic [`DATA_W-1:0] d,
                                                     input logic [`LANE_CNT-1:0] inv);
        logic [`DATA_W-1:0] r;
        r = d;
        for (int l = 0; l < `LANE_CNT; l++) begin
            if (inv[l]) begin
                r[l*`LANE_W +: `LANE_W] = ~d[l*`LANE_W +: `LANE_W];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe domain capture

    bus_groups_pkg::core_st_t core_ff;
    bus_groups_pkg::core_st_t nxt_core;
    bus_groups_pkg::link_st_t lk_ff;
    bus_groups_pkg::link_st_t nxt_lk;
    logic lk_rst_sync;
    logic ack_sync;
    logic req_sync;
    logic [`SB_W-1:0] sb_sync;
    logic [`ADDR_STRAP_W-1:0] addr_sync;
    logic hot_sync;

    // Word is taken on the strobe and held until the bus clock side acknowledges
    always_comb begin
        nxt_lk = lk_ff;
        if (lane_capture_in && (lk_ff.req_tgl == ack_sync)) begin
            nxt_lk.cap.data = lane_flip(~data_lane_n_in, ~lane_inversion_flags_n_in);
            nxt_lk.req_tgl = ~lk_ff.req_tgl;
        end
        // No reset pin of its own: follows the core reset so the toggle pair starts equal
        if (lk_rst_sync) begin
            nxt_lk = '0;
        end
    end

    // Strobe clock may stop between bursts; the pending toggle simply waits
    always_ff @(posedge strobe_clk_in) begin
        lk_ff <= nxt_lk;
    end

    sync_two_stage #(.W(1)) u_ack_sync (
        .clk_in(strobe_clk_in),
        .d_in(core_ff.ack_tgl),
        .q_out(ack_sync)
    );

    // Core reset brought over; the strobe clock must run while reset is held
    sync_two_stage #(.W(1)) u_rst_sync (
        .clk_in(strobe_clk_in),
        .d_in(rst_in),
        .q_out(lk_rst_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings into the bus clock domain

    sync_two_stage #(.W(1)) u_req_sync (
        .clk_in(core_clk_in),
        .d_in(lk_ff.req_tgl),
        .q_out(req_sync)
    );

    // Every asynchronous pin passes two flops first
    sync_two_stage #(.W(`SB_W + `ADDR_STRAP_W + 1)) u_sb_sync (
        .clk_in(core_clk_in),
        .d_in({~thermal_throttle_indicator_n_in, ~addr_strap_n_in,
               ~management_interrupt_n_in, ~soft_init_n_in, local_irq_pin_b_in,
               local_irq_pin_a_in, ~numeric_error_ignore_n_in, ~gate_a20_mask_n_in}),
        .q_out({hot_sync, addr_sync, sb_sync})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus clock domain

    always_comb begin
        nxt_core = core_ff;
        nxt_core.rst_d = rst_in;
        // Common-clock sampling and driving on the rising edge
        nxt_core.ads_seen = ~address_strobe_common_n_in;
        nxt_core.ads_drv = ads_req_in;
        // Pin reads as asserted when any agent pulls it; ours never fights theirs
        nxt_core.wor_seen = ~wor_n_in;
        nxt_core.wor_drv = wor_req_in;
        // Only two request lines exist on this agent
        nxt_core.arb_drv = arb_req_in;
        // Recognised only after two consecutive synchronised samples
        nxt_core.sb_prev = sb_sync;
        nxt_core.sb_valid = sb_sync & core_ff.sb_prev;
        nxt_core.hot_drv = hot_req_in;
        // Output-only stepping ignores pulls from outside
        nxt_core.hot_ext = THERM_OUTPUT_ONLY ? 1'b0 : hot_sync;
        // Straps caught in the first cycle after reset release
        if (core_ff.rst_d && !rst_in) begin
            nxt_core.ratio = {sb_sync[`SB_IRQ_B], sb_sync[`SB_IRQ_A],
                              sb_sync[`SB_NUMERIC_ERROR_IGNORE], sb_sync[`SB_A20]};
            nxt_core.cfg = {addr_sync, sb_sync[`SB_SMI], sb_sync[`SB_INIT]};
        end
        // New word from the strobe domain: take it, acknowledge, pulse valid
        nxt_core.req_prev = req_sync;
        nxt_core.rx_valid = 1'b0;
        if (req_sync != core_ff.req_prev) begin
            nxt_core.rx = lk_ff.cap;
            nxt_core.rx_valid = 1'b1;
            nxt_core.ack_tgl = req_sync;
        end
        // Transmit: invert a lane when more than half its bits would be driven
        nxt_core.tx_oe = tx_valid_in;
        if (tx_valid_in) begin
            for (int l = 0; l < `LANE_CNT; l++) begin
                nxt_core.tx_inv[l] = (ones16(tx_data_in[l*`LANE_W +: `LANE_W])
                                      > LANE_INV_LIMIT[4:0]);
            end
            nxt_core.tx_data = lane_flip(tx_data_in, nxt_core.tx_inv);
        end
        // Toggle pair clears together with the strobe side, so no word looks pending;
        // straps show their reset value until the next release
        if (rst_in) begin
            nxt_core = '0;
            nxt_core.rst_d = 1'b1;
            nxt_core.ratio = `RATIO_RST;
            nxt_core.cfg = `CFG_RST;
        end
    end

    // One register for the whole bus clock domain state
    always_ff @(posedge core_clk_in) begin
        core_ff <= nxt_core;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops; open drain drives low only while enabled

    assign address_strobe_common_n_out = 1'b0;
    assign address_strobe_common_oe_out = core_ff.ads_drv;
    assign wor_n_out = '0;
    assign wor_oe_out = core_ff.wor_drv;
    assign arb_request_n_out = ~core_ff.arb_drv;
    assign arb_request_oe_out = {`ARB_W{1'b1}}; // lines two and three do not exist here
    assign thermal_throttle_indicator_n_out = 1'b0;
    assign thermal_throttle_indicator_oe_out = core_ff.hot_drv;
    assign data_lane_n_out = ~core_ff.tx_data;
    assign lane_inversion_flags_n_out = ~core_ff.tx_inv;
    assign data_lane_oe_out = core_ff.tx_oe;
    assign ads_seen_out = core_ff.ads_seen;
    assign wor_seen_out = core_ff.wor_seen;
    assign sideband_out = core_ff.sb_valid;
    assign hot_ext_out = core_ff.hot_ext;
    assign core_ratio_out = core_ff.ratio;
    assign config_opts_out = core_ff.cfg;
    assign rx_data_out = core_ff.rx.data;
    assign rx_valid_out = core_ff.rx_valid;

endmodule

// >>> tb/bus_signal_groups_chk.sv
// Port checker of the bus signal group block
`timescale 1ns/1ns
module bus_signal_groups_chk (
    // Clock, reset and pins seen at the ports
    input wire logic core_clk_in, rst_in, ads_req_in, address_strobe_common_n_in, hot_req_in,
    input wire logic gate_a20_mask_n_in, numeric_error_ignore_n_in,
    input wire logic local_irq_pin_a_in, local_irq_pin_b_in,
    input wire logic [3:0] wor_n_in, wor_req_in, wor_oe_out, wor_seen_out, core_ratio_out,
    input wire logic [1:0] arb_req_in, arb_request_n_out, arb_request_oe_out,
    input wire logic [5:0] sideband_out,
    input wire logic address_strobe_common_oe_out, ads_seen_out, rx_valid_out,
    input wire logic thermal_throttle_indicator_oe_out, hot_ext_out,
    input wire logic thermal_throttle_indicator_n_in
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Common-clock drive and sample, one edge apart
    chk_strobe_drive: assert property (ads_req_in |=> address_strobe_common_oe_out)
        else $error("address strobe not driven after request");
    chk_strobe_sample: assert property (!address_strobe_common_n_in |=> ads_seen_out)
        else $error("address strobe assertion not seen");
    chk_wor_drive: assert property (1'b1 |=> wor_oe_out == $past(wor_req_in))
        else $error("wired-or drive does not follow request");
    chk_wor_sample: assert property (1'b1 |=> wor_seen_out == ~$past(wor_n_in))
        else $error("wired-or pin level not reported");
    chk_arb_level: assert property ($changed(arb_req_in) |=>
        arb_request_n_out == ~$past(arb_req_in))
        else $error("arbitration request level wrong");
    chk_arb_enable: assert property (arb_request_oe_out == 2'h3)
        else $error("arbitration request not driven");
    chk_hot_drive: assert property ($rose(hot_req_in) |=>
        $rose(thermal_throttle_indicator_oe_out))
        else $error("thermal pin not driven after request");
    // Pin level passes two sync flops and one state flop before it is reported
    chk_hot_ext: assert property (
        hot_ext_out == !$past(thermal_throttle_indicator_n_in, 3))
        else $error("thermal pin pull not reported");
    chk_rx_pulse: assert property (rx_valid_out |=> !rx_valid_out)
        else $error("receive valid longer than one cycle");
    // Six cycles of a held level cover sync pipe plus the two-clock recognition
    chk_async_seen: assert property ((!gate_a20_mask_n_in) [*6] |-> sideband_out[0])
        else $error("held side-band input not recognised");
    chk_ratio_latch: assert property ($fell(rst_in) |=> core_ratio_out ==
        {local_irq_pin_b_in, local_irq_pin_a_in, !numeric_error_ignore_n_in, !gate_a20_mask_n_in})
        else $error("multiplier straps not latched at release");
endmodule
bind bus_signal_groups bus_signal_groups_chk u_chk (.*);

// >>> tb/lane_partner.sv
// Far-side lane driver with its own strobe clock
`timescale 1ns/1ns
module lane_partner (
    // Strobe clock and receive lanes toward the block
    output logic strobe_clk_out,
    output logic [63:0] data_lane_n_out,
    output logic [3:0] flags_n_out,
    output logic capture_out
);
    initial begin
        strobe_clk_out = 1'b0;
        data_lane_n_out = 64'h0;
        flags_n_out = 4'hF;
        capture_out = 1'b0;
    end
    // Clock runs only inside a frame; lines show the inverse once the word is taken
    task automatic frame(input logic go, input logic [63:0] w, input logic [3:0] inv);
        for (int k = 0; k < 8; k++) begin
            if (k == 4 && go) begin
                capture_out = 1'b1;
                for (int l = 0; l < 4; l++)
                    data_lane_n_out[16*l +: 16] = inv[l] ? w[16*l +: 16] : ~w[16*l +: 16];
                flags_n_out = ~inv;
            end else if (k == 5) begin
                capture_out = 1'b0;
                data_lane_n_out = ~data_lane_n_out;
                flags_n_out = ~flags_n_out;
            end
            #8 strobe_clk_out = 1'b1;
            #7 strobe_clk_out = 1'b0;
        end
    endtask
endmodule

// >>> tb/tb_bus_signal_groups.sv
// Self-checking bench of the bus signal group block
`timescale 1ns/1ns
module tb_bus_signal_groups;
    logic core_clk_in = 1'b0, rst_in = 1'b1, ads_req_in = 1'b0, hot_req_in = 1'b0;
    logic tx_valid_in = 1'b0, oth_strobe = 1'b0, oth_hot = 1'b0;
    logic [3:0] wor_req_in = 4'h0, oth_wor = 4'h0, wor_oe_out, wor_seen_out, core_ratio_out;
    logic [1:0] arb_req_in = 2'h0, arb_request_n_out, arb_request_oe_out;
    logic [63:0] tx_data_in = 64'h0, data_lane_n_out, rx_data_out, w;
    logic [5:0] sb_act = 6'h0, sideband_out;
    logic [13:0] addr_act = 14'h0;
    logic [3:0] lane_inversion_flags_n_out, iv;
    logic [15:0] config_opts_out;
    logic address_strobe_common_oe_out, thermal_throttle_indicator_oe_out, data_lane_oe_out;
    logic ads_seen_out, hot_ext_out, rx_valid_out;
    logic [67:0] txq[$];
    logic [67:0] exp_v;
    logic [63:0] rxq[$];
    int n_mismatch = 0, num_checks = 0, cyc = 0, k, seed_v;
    wire strobe_clk_in, lane_capture_in;
    wire [63:0] data_lane_n_in;
    wire [3:0] lane_inversion_flags_n_in;
    // Open-drain wires: low while any agent pulls
    wire address_strobe_common_n_in = ~(address_strobe_common_oe_out | oth_strobe);
    wire [3:0] wor_n_in = ~(wor_oe_out | oth_wor);
    wire thermal_throttle_indicator_n_in = ~(thermal_throttle_indicator_oe_out | oth_hot);
    // Side-band pins from asserted levels
    wire gate_a20_mask_n_in = ~sb_act[0], numeric_error_ignore_n_in = ~sb_act[1];
    wire local_irq_pin_a_in = sb_act[2], local_irq_pin_b_in = sb_act[3];
    wire soft_init_n_in = ~sb_act[4], management_interrupt_n_in = ~sb_act[5];
    wire [13:0] addr_strap_n_in = ~addr_act;
    always #4 core_clk_in = ~core_clk_in;
    bus_signal_groups u_bus_signal_groups (.core_clk_in, .rst_in, .strobe_clk_in,
        .address_strobe_common_n_in, .address_strobe_common_n_out(), .address_strobe_common_oe_out,
        .wor_n_in, .wor_n_out(), .wor_oe_out, .arb_request_n_out, .arb_request_oe_out,
        .gate_a20_mask_n_in, .numeric_error_ignore_n_in, .local_irq_pin_a_in, .local_irq_pin_b_in,
        .soft_init_n_in, .management_interrupt_n_in, .addr_strap_n_in,
        .thermal_throttle_indicator_n_in, .thermal_throttle_indicator_n_out(),
        .thermal_throttle_indicator_oe_out, .data_lane_n_in, .lane_inversion_flags_n_in,
        .lane_capture_in, .data_lane_n_out, .lane_inversion_flags_n_out, .data_lane_oe_out,
        .ads_req_in, .wor_req_in, .arb_req_in, .hot_req_in, .tx_valid_in, .tx_data_in,
        .ads_seen_out, .wor_seen_out, .sideband_out, .hot_ext_out, .core_ratio_out,
        .config_opts_out, .rx_data_out, .rx_valid_out);
    lane_partner u_lane_partner (.strobe_clk_out(strobe_clk_in), .data_lane_n_out(data_lane_n_in),
        .flags_n_out(lane_inversion_flags_n_in), .capture_out(lane_capture_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [67:0] exp, input logic [67:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Lane encoding: invert a lane holding more than eight ones
    function automatic logic [67:0] enc(input logic [63:0] v);
        logic [3:0] inv;
        logic [63:0] d;
        for (int l = 0; l < 4; l++) begin
            inv[l] = $countones(v[16*l +: 16]) > 8;
            d[16*l +: 16] = inv[l] ? v[16*l +: 16] : ~v[16*l +: 16];
        end
        return {~inv, d};
    endfunction
    // Results are matched against the oldest note; an empty queue gives x and fails
    // Looked at on the falling edge, where registered outputs have settled
    always @(negedge core_clk_in) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            complete_run();
        end else begin
            if (data_lane_oe_out === 1'b1) begin
                exp_v = txq.size() ? txq.pop_front() : 'x;
                cmp("tx lanes", exp_v, {lane_inversion_flags_n_out, data_lane_n_out});
            end
            if (rx_valid_out === 1'b1)
                cmp("rx word", rxq.size() ? rxq.pop_front() : 'x, rx_data_out);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed_v = $urandom(25664);
        // Straps over two resets; pins held well across release
        for (int r = 0; r < 2; r++) begin
            @(negedge core_clk_in);
            rst_in = 1'b1;
            sb_act = 6'($urandom);
            addr_act = 14'($urandom);
            u_lane_partner.frame(1'b0, 64'h0, 4'h0);
            repeat (20) @(negedge core_clk_in);
            rst_in = 1'b0;
            repeat (2) @(negedge core_clk_in);
            cmp("ratio", sb_act[3:0], core_ratio_out);
            cmp("config", {addr_act, sb_act[5:4]}, config_opts_out);
            sb_act = 6'h0;
        end
        $display("test straps done");
        // Common-clock traffic, other agents pulling the same wires
        repeat (60) begin
            @(negedge core_clk_in);
            {ads_req_in, hot_req_in, wor_req_in, arb_req_in} = 8'($urandom);
            {oth_strobe, oth_wor, oth_hot} = 6'($urandom);
        end
        {ads_req_in, hot_req_in, wor_req_in, arb_req_in, oth_strobe, oth_wor, oth_hot} = 14'h0;
        $display("test common clock done");
        // Each side-band input set mid-cycle, held until seen (up to eight clocks), then clear for eight
        for (int b = 0; b < 6; b++) begin
            @(negedge core_clk_in);
            #($urandom_range(3)) sb_act[b] = 1'b1;
            k = 0;
            while (sideband_out[b] !== 1'b1 && k < 8) begin
                @(negedge core_clk_in);
                k++;
            end
            cmp("sideband set", 1'b1, sideband_out[b]);
            sb_act[b] = 1'b0;
            repeat (8) @(negedge core_clk_in);
            cmp("sideband clear", 1'b0, sideband_out[b]);
        end
        $display("test side-band done");
        // Receive words on the strobe clock, lanes randomly inverted
        for (int i = 0; i < 6; i++) begin
            w = {$urandom, $urandom};
            iv = 4'($urandom);
            rxq.push_back(w);
            #($urandom_range(7)) u_lane_partner.frame(1'b1, w, iv);
            repeat (6) @(negedge core_clk_in);
        end
        $display("test receive done");
        // Back-to-back transmit; first word has lanes of 0, 16, 9 and 8 ones
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk_in);
            w = (i == 0) ? 64'h00FF_01FF_FFFF_0000 : {$urandom, $urandom};
            tx_valid_in = 1'b1;
            tx_data_in = w;
            txq.push_back(enc(w));
        end
        @(negedge core_clk_in);
        tx_valid_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        cmp("queues left", 68'h0, txq.size() + rxq.size());
        $display("test transmit done");
        complete_run();
    end
endmodule
